// file: shared/usf_regs.svh
// Register offsets, field positions and reset values for the status block
`ifndef USF_REGS_SVH
`define USF_REGS_SVH
`define USF_OFF_CTRL1 8'h00
`define USF_OFF_CTRL2 8'h04
`define USF_OFF_CTRL3 8'h08
`define USF_OFF_BAUD 8'h0C
`define USF_OFF_GUARD 8'h10
`define USF_OFF_RTO 8'h14
`define USF_OFF_REQ 8'h18
`define USF_OFF_STAT 8'h1C
`define USF_OFF_CLR 8'h20
`define USF_OFF_RXD 8'h24
`define USF_OFF_TXD 8'h28
// Control one fields
`define USF_C1_IDLE_IRQ 4
`define USF_C1_RXFIE 5
`define USF_C1_PAR_IRQ 8
`define USF_C1_PAR_EN 10
`define USF_C1_M0 12
`define USF_C1_MUTE_EN 13
`define USF_C1_M1 28
// Control three fields
`define USF_C3_ERR_IRQ 0
`define USF_C3_OVR_OFF 12
// Request fields
`define USF_RQ_RXFLUSH 3
// Status / clear bit positions
`define USF_B_PAR 0
`define USF_B_FRM 1
`define USF_B_NOISE 2
`define USF_B_OVR 3
`define USF_B_IDLE 4
`define USF_B_RXF 5
`define USF_B_TXDONE 6
`define USF_B_TXEMPTY 7
`define USF_B_LBD 8
`define USF_B_CTSI 9
`define USF_B_RTO 11
`define USF_B_EOB 12
`define USF_B_MUTE 19
`define USF_B_CM 17
`define USF_B_WU 20
`define USF_B_GUARD 25
`define USF_CLR_GUARD 7
`define USF_CLR_MASK 32'h00121BDF
`define USF_RST_ZERO 32'h00000000
`define USF_RST_STAT 32'h000000C0
`define USF_SMARTCARD 1'b0
`endif

// file: shared/usf_pkg.sv
// Types for the status block
package usf_pkg;
  typedef logic [31:0] usf_word_t;
  typedef logic [8:0] usf_char_t;
  typedef enum logic [1:0] {
    USF_BUS_IDLE = 2'b00,
    USF_BUS_ACK = 2'b01
  } usf_bus_e;
endpackage

// file: core/usf_status_regs.sv
// Status flags, flag clear and data registers of the serial transceiver
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`include "usf_regs.svh"
module usf_status_regs (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire usf_pkg::usf_word_t wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive engine events
  input wire logic rx_char_done,
  input wire usf_pkg::usf_char_t rx_char,
  input wire logic idle_detect,
  input wire logic muted_state,
  input wire logic noise_detect,
  input wire logic framing_detect,
  input wire logic sc_retry_exhausted,
  input wire logic parity_detect,
  input wire logic multibuffer,
  // Other flag sources
  input wire logic tx_shift_load,
  input wire logic tx_frame_done,
  input wire logic line_break_set,
  input wire logic flow_change_set,
  input wire logic receive_timeout_set,
  input wire logic end_of_block_set,
  input wire logic char_match_set,
  input wire logic wakeup_set,
  // Transmit side and interrupt
  output usf_pkg::usf_char_t tx_char,
  output logic tx_char_valid,
  output logic irq
);
  import usf_pkg::*;

  usf_word_t ctrl1_reg, ctrl1_next;
  usf_word_t ctrl2_reg, ctrl2_next;
  usf_word_t ctrl3_reg, ctrl3_next;
  usf_word_t baud_reg, baud_next;
  usf_word_t guard_reg, guard_next;
  usf_word_t rto_reg, rto_next;
  usf_word_t flags_reg, flags_next;
  usf_char_t rxd_reg, rxd_next;
  usf_char_t txd_reg, txd_next;
  logic idle_armed_reg, idle_armed_next;
  logic tx_valid_reg, tx_valid_next;
  logic irq_reg, irq_next;
  usf_bus_e bus_reg, bus_next;
  usf_word_t rdata_reg, rdata_next;
  logic ack_reg, ack_next;

  logic req;
  logic wr;
  logic rd;
  usf_word_t wmask;
  usf_word_t wdata;
  usf_word_t clr;

  // Byte-lane write mask from sel
  function automatic usf_word_t lane_mask(input logic [3:0] sel);
    usf_word_t m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  // Merge a write into a register under the lane mask
  function automatic usf_word_t merge(input usf_word_t old, input usf_word_t nw,
                                      input usf_word_t m);
    return (old & ~m) | (nw & m);
  endfunction

  assign req = wb_cyc_i && wb_stb_i && (bus_reg == USF_BUS_IDLE) && clk_en;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign wmask = lane_mask(wb_sel_i);
  assign wdata = wb_dat_i & wmask;
  assign clr = (wr && wb_adr_i == `USF_OFF_CLR) ? wdata : 32'h00000000;

  // Bus answer and read mux
  always_comb
  begin
    bus_next = bus_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    if (bus_reg == USF_BUS_ACK)
    begin
      bus_next = USF_BUS_IDLE;
    end
    else if (req)
    begin
      bus_next = USF_BUS_ACK;
      ack_next = 1'b1;
      case (wb_adr_i)
        `USF_OFF_CTRL1: rdata_next = ctrl1_reg;
        `USF_OFF_CTRL2: rdata_next = ctrl2_reg;
        `USF_OFF_CTRL3: rdata_next = ctrl3_reg;
        `USF_OFF_BAUD: rdata_next = baud_reg;
        `USF_OFF_GUARD: rdata_next = guard_reg;
        `USF_OFF_RTO: rdata_next = rto_reg;
        `USF_OFF_STAT: rdata_next = flags_reg;
        `USF_OFF_RXD: rdata_next = {23'h000000, rxd_reg};
        `USF_OFF_TXD: rdata_next = {23'h000000, txd_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Control registers
  always_comb
  begin
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    ctrl3_next = ctrl3_reg;
    baud_next = baud_reg;
    guard_next = guard_reg;
    rto_next = rto_reg;
    if (wr)
    begin
      case (wb_adr_i)
        `USF_OFF_CTRL1: ctrl1_next = merge(ctrl1_reg, wb_dat_i, wmask) & 32'h1FFFFFFF;
        `USF_OFF_CTRL2: ctrl2_next = merge(ctrl2_reg, wb_dat_i, wmask);
        `USF_OFF_CTRL3: ctrl3_next = merge(ctrl3_reg, wb_dat_i, wmask) & 32'h01FEFFFF;
        `USF_OFF_BAUD: baud_next = merge(baud_reg, wb_dat_i, wmask) & 32'h0000FFFF;
        `USF_OFF_GUARD: guard_next = merge(guard_reg, wb_dat_i, wmask) & 32'h0000FFFF;
        `USF_OFF_RTO: rto_next = merge(rto_reg, wb_dat_i, wmask);
        default: ctrl1_next = ctrl1_reg;
      endcase
    end
  end

  logic par_en;
  logic nine_bit;
  logic seven_bit;
  logic ovr_off;
  logic err_irq_en;
  logic flush;
  logic rxd_read;
  logic txd_write;
  logic rx_move;
  logic idle_set;
  usf_word_t set_v;

  assign par_en = ctrl1_reg[`USF_C1_PAR_EN];
  assign nine_bit = !ctrl1_reg[`USF_C1_M1] && ctrl1_reg[`USF_C1_M0];
  assign seven_bit = ctrl1_reg[`USF_C1_M1] && !ctrl1_reg[`USF_C1_M0];
  assign ovr_off = ctrl3_reg[`USF_C3_OVR_OFF];
  assign err_irq_en = ctrl3_reg[`USF_C3_ERR_IRQ];
  assign flush = wr && wb_adr_i == `USF_OFF_REQ && wdata[`USF_RQ_RXFLUSH];
  assign rxd_read = rd && wb_adr_i == `USF_OFF_RXD;
  assign txd_write = wr && wb_adr_i == `USF_OFF_TXD;
  assign rx_move = rx_char_done && !flags_reg[`USF_B_RXF];
  // Idle gated by arm and mute
  assign idle_set = idle_detect && idle_armed_reg &&
                    !(ctrl1_reg[`USF_C1_MUTE_EN] && muted_state);

  // Hardware set vector
  always_comb
  begin
    set_v = 32'h00000000;
    set_v[`USF_B_RXF] = rx_char_done;
    set_v[`USF_B_IDLE] = idle_set;
    set_v[`USF_B_OVR] = rx_char_done && flags_reg[`USF_B_RXF] && !ovr_off;
    set_v[`USF_B_NOISE] = rx_char_done && noise_detect;
    set_v[`USF_B_FRM] = (rx_char_done && framing_detect) || sc_retry_exhausted;
    set_v[`USF_B_PAR] = rx_char_done && parity_detect;
    set_v[`USF_B_TXDONE] = tx_frame_done;
    set_v[`USF_B_TXEMPTY] = tx_shift_load;
    set_v[`USF_B_LBD] = line_break_set;
    set_v[`USF_B_CTSI] = flow_change_set;
    set_v[`USF_B_RTO] = receive_timeout_set;
    set_v[`USF_B_EOB] = end_of_block_set;
    set_v[`USF_B_CM] = char_match_set;
    set_v[`USF_B_WU] = wakeup_set;
  end

  // Flags, data and interrupt
  always_comb
  begin
    usf_word_t c;
    c = clr & `USF_CLR_MASK;
    c[`USF_CLR_GUARD] = c[`USF_CLR_GUARD] & `USF_SMARTCARD;
    c[`USF_B_RXF] = rxd_read || flush;
    // Transmit write clears empty and complete
    c[`USF_B_TXEMPTY] = txd_write;
    c[`USF_B_TXDONE] = clr[`USF_B_TXDONE] || txd_write;
    flags_next = (flags_reg & ~c) | set_v;
    flags_next[`USF_B_GUARD] = 1'b0;
    flags_next[`USF_B_MUTE] = muted_state;
    if (ovr_off)
    begin
      flags_next[`USF_B_OVR] = 1'b0;
    end
    idle_armed_next = idle_armed_reg;
    if (idle_set)
    begin
      idle_armed_next = 1'b0;
    end
    if (rx_char_done)
    begin
      idle_armed_next = 1'b1;
    end
    // Received character with parity in top bit
    rxd_next = rx_move ? rx_char : rxd_reg;
    txd_next = txd_reg;
    if (txd_write)
    begin
      txd_next = wdata[8:0];
      if (par_en && nine_bit)
      begin
        txd_next[8] = 1'b0;
      end
      else if (par_en && !seven_bit)
      begin
        txd_next[7] = 1'b0;
      end
      else if (par_en)
      begin
        txd_next[6] = 1'b0;
      end
    end
    tx_valid_next = txd_write ? 1'b1 : (tx_shift_load ? 1'b0 : tx_valid_reg);
    irq_next = (flags_reg[`USF_B_RXF] && ctrl1_reg[`USF_C1_RXFIE]) ||
               (flags_reg[`USF_B_IDLE] && ctrl1_reg[`USF_C1_IDLE_IRQ]) ||
               (flags_reg[`USF_B_OVR] && (ctrl1_reg[`USF_C1_RXFIE] || err_irq_en)) ||
               (flags_reg[`USF_B_NOISE] && multibuffer && err_irq_en) ||
               (flags_reg[`USF_B_FRM] && err_irq_en) ||
               (flags_reg[`USF_B_PAR] && ctrl1_reg[`USF_C1_PAR_IRQ]);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ctrl1_reg <= `USF_RST_ZERO;
      ctrl2_reg <= `USF_RST_ZERO;
      ctrl3_reg <= `USF_RST_ZERO;
      baud_reg <= `USF_RST_ZERO;
      guard_reg <= `USF_RST_ZERO;
      rto_reg <= `USF_RST_ZERO;
      flags_reg <= `USF_RST_STAT;
      rxd_reg <= 9'h000;
      txd_reg <= 9'h000;
      idle_armed_reg <= 1'b1;
      tx_valid_reg <= 1'b0;
      irq_reg <= 1'b0;
      bus_reg <= USF_BUS_IDLE;
      ack_reg <= 1'b0;
      rdata_reg <= `USF_RST_ZERO;
    end
    else if (clk_en)
    begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      ctrl3_reg <= ctrl3_next;
      baud_reg <= baud_next;
      guard_reg <= guard_next;
      rto_reg <= rto_next;
      flags_reg <= flags_next;
      rxd_reg <= rxd_next;
      txd_reg <= txd_next;
      idle_armed_reg <= idle_armed_next;
      tx_valid_reg <= tx_valid_next;
      irq_reg <= irq_next;
      bus_reg <= bus_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign tx_char = txd_reg;
  assign tx_char_valid = tx_valid_reg;
  assign irq = irq_reg;

  a_rxf_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && rx_char_done |=> flags_reg[`USF_B_RXF])
    else $error("receive-full not set");
  a_rxf_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && flags_reg[`USF_B_RXF] && ctrl1_reg[`USF_C1_RXFIE] |=> irq)
    else $error("receive-full interrupt missing");
  a_idle_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && flags_reg[`USF_B_IDLE] && !clr[`USF_B_IDLE] |=> flags_reg[`USF_B_IDLE])
    else $error("idle flag lost");
  a_idle_mute: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !flags_reg[`USF_B_IDLE] && ctrl1_reg[`USF_C1_MUTE_EN] && muted_state
    |=> !flags_reg[`USF_B_IDLE])
    else $error("idle set while muted");
  a_ovr_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && rx_char_done && flags_reg[`USF_B_RXF] |=> $stable(rxd_reg))
    else $error("data lost on overrun");
  a_ovr_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && flags_reg[`USF_B_OVR] && err_irq_en |=> irq)
    else $error("overrun interrupt missing");
  a_ovr_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && ovr_off |=> !flags_reg[`USF_B_OVR])
    else $error("overrun set while disabled");
  a_rxd_upper: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && rxd_read |=> wb_ack_o && wb_dat_o[31:9] == 23'h000000)
    else $error("receive data upper bits set");
  a_txd_parity: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && txd_write && par_en && nine_bit |=> !tx_char[8])
    else $error("parity position kept");
  a_txe_clr: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && txd_write && !tx_shift_load |=> !flags_reg[`USF_B_TXEMPTY])
    else $error("transmit-empty not cleared");
  a_tc_clr: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && txd_write && !tx_frame_done |=> !flags_reg[`USF_B_TXDONE])
    else $error("transmit complete not cleared");
  a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && set_v[`USF_B_PAR] && clr[`USF_B_PAR] |=> flags_reg[`USF_B_PAR])
    else $error("parity event lost");

  c_overrun: cover property (@(posedge core_clk) disable iff (!rst_b)
    flags_reg[`USF_B_OVR]);
  c_tx_load: cover property (@(posedge core_clk) disable iff (!rst_b)
    tx_shift_load && tx_valid_reg);
  c_rx_read: cover property (@(posedge core_clk) disable iff (!rst_b)
    rxd_read && flags_reg[`USF_B_RXF]);
  c_idle: cover property (@(posedge core_clk) disable iff (!rst_b)
    flags_reg[`USF_B_IDLE] ##1 clr[`USF_B_IDLE]);
endmodule

// file: tb/usf_line_partner.sv
// Behavioural receive engine and transmit shifter beside the status block
`timescale 1ns/10ps
module usf_line_partner (
  // Clock
  input wire logic core_clk,
  // Receive events toward the block
  output logic rx_char_done,
  output usf_pkg::usf_char_t rx_char,
  output logic noise_detect,
  output logic framing_detect,
  output logic parity_detect,
  // Transmit side, from the block and the load strobe back to it
  input wire usf_pkg::usf_char_t tx_char,
  input wire logic tx_char_valid,
  output logic tx_shift_load
);
  import usf_pkg::*;
  initial
  begin
    rx_char_done = 1'b0;
    rx_char = 9'h000;
    {noise_detect, framing_detect, parity_detect} = 3'b000;
    tx_shift_load = 1'b0;
  end
  // One character with its error qualifiers
  task automatic send(input usf_char_t c, input logic [2:0] err);
    @(posedge core_clk);
    rx_char_done <= 1'b1;
    rx_char <= c;
    {noise_detect, framing_detect, parity_detect} <= err;
    @(posedge core_clk);
    rx_char_done <= 1'b0;
    rx_char <= ~c;
    {noise_detect, framing_detect, parity_detect} <= 3'b000;
  endtask
  // Shifter takes the pending character, promptly or late
  task automatic load(input int wait_cyc, output usf_char_t got);
    repeat (wait_cyc) @(posedge core_clk);
    @(posedge core_clk);
    got = tx_char;
    tx_shift_load <= 1'b1;
    @(posedge core_clk);
    tx_shift_load <= 1'b0;
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the status flags and data registers
`timescale 1ns/10ps
`include "usf_regs.svh"
module tb_top;
  import usf_pkg::*;
  logic core_clk, rst_b, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic rx_char_done, noise_detect, framing_detect, parity_detect, tx_shift_load;
  logic muted_state, multibuffer, tx_char_valid;
  logic [8:0] ev;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_o, q, lfsr_q, m_stat, c1, c3, m_rxd;
  usf_word_t wb_dat_i;
  usf_char_t rx_char, tx_char, got;
  int err_count, n_checks, m_arm;
  int sb[8] = '{8, 9, 11, 12, 17, 20, 1, 6};
  usf_status_regs usf_status_regs_inst (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_char_done(rx_char_done), .rx_char(rx_char), .idle_detect(ev[8]),
    .muted_state(muted_state), .noise_detect(noise_detect),
    .framing_detect(framing_detect), .sc_retry_exhausted(ev[6]),
    .parity_detect(parity_detect), .multibuffer(multibuffer),
    .tx_shift_load(tx_shift_load), .tx_frame_done(ev[7]), .line_break_set(ev[0]),
    .flow_change_set(ev[1]), .receive_timeout_set(ev[2]), .end_of_block_set(ev[3]),
    .char_match_set(ev[4]), .wakeup_set(ev[5]), .tx_char(tx_char),
    .tx_char_valid(tx_char_valid), .irq(irq)
  );
  usf_line_partner usf_line_partner_inst (
    .core_clk(core_clk), .rx_char_done(rx_char_done), .rx_char(rx_char),
    .noise_detect(noise_detect), .framing_detect(framing_detect),
    .parity_detect(parity_detect), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_shift_load(tx_shift_load)
  );
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic m_irq();
    return (m_stat[5] && c1[5]) || (m_stat[4] && c1[4]) || (m_stat[3] && (c1[5] || c3[0]))
      || (m_stat[0] && c1[8]) || (m_stat[1] && c3[0]) || (m_stat[2] && c3[0] && multibuffer);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Classic single cycle, held until ack is seen high
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50)
      chk("ack", 32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    case (a)
      `USF_OFF_CTRL1: c1 = d;
      `USF_OFF_CTRL3: c3 = d;
      `USF_OFF_CLR: m_stat &= ~(d & 32'h00121B5F);
      `USF_OFF_REQ: m_stat[5] = m_stat[5] & ~d[3];
      `USF_OFF_TXD: m_stat[7:6] = 2'b00;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask
  task automatic rd_stat();
    m_stat[19] = muted_state;
    rd(`USF_OFF_STAT, m_stat, "status");
    chk("irq", {31'h0, irq}, {31'h0, m_irq()});
  endtask
  task automatic rd_rxd();
    rd(`USF_OFF_RXD, m_rxd, "rx data");
    m_stat[5] = 1'b0;
  endtask
  task automatic rx(input logic [2:0] err);
    lfsr_q = lfsr_next(lfsr_q);
    usf_line_partner_inst.send(lfsr_q[8:0], err);
    if (m_stat[5] && !c3[12])
      m_stat[3] = 1'b1;
    if (!m_stat[5])
      m_rxd = {23'h0, lfsr_q[8:0]};
    m_stat[5] = 1'b1;
    m_stat[2:0] = m_stat[2:0] | err;
    m_arm = 1;
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
    if (clk_en && i < 8)
      m_stat[sb[i]] = 1'b1;
    else if (clk_en && i == 8 && m_arm == 1 && !(c1[13] && muted_state))
    begin
      m_stat[4] = 1'b1;
      m_arm = 0;
    end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
  initial
  begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, muted_state, multibuffer} = 6'b000000;
    {clk_en, wb_adr_i, wb_sel_i, wb_dat_i, ev} = {1'b1, 8'h00, 4'h0, 32'h0, 9'h000};
    {lfsr_q, m_stat, c1, c3, m_rxd} = {32'h6411B333, 32'h000000C0, 96'h0};
    {m_arm, err_count, n_checks} = {32'd1, 64'd0};
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_stat();
    rd(`USF_OFF_RXD, 32'h0, "rx data reset");
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, "unmapped");
    wr(`USF_OFF_CTRL1, 32'h130);
    wr(`USF_OFF_CTRL3, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      multibuffer <= lfsr_q[3];
      rx(lfsr_q[2:0]);
      rd_stat();
      rd_rxd();
      rd_stat();
      wr(`USF_OFF_CLR, 32'h0);
      rd_stat();
      wr(`USF_OFF_CLR, 32'h7);
      rd_stat();
    end
    fork
      rx(3'b001);
      wr(`USF_OFF_CLR, 32'h1);
    join
    m_stat[0] = 1'b1;
    rd_stat();
    rd_rxd();
    wr(`USF_OFF_CLR, 32'h1);
    wr(`USF_OFF_CTRL1, 32'h0);
    rx(3'b000);
    rx(3'b000);
    rd_stat();
    rd_rxd();
    wr(`USF_OFF_CLR, 32'h8);
    rd_stat();
    wr(`USF_OFF_CTRL3, 32'h1001);
    rx(3'b000);
    rx(3'b000);
    rd_stat();
    wr(`USF_OFF_REQ, 32'h8);
    rd_stat();
    wr(`USF_OFF_CTRL1, 32'h2010);
    pulse(8);
    rd_stat();
    wr(`USF_OFF_CLR, 32'h10);
    pulse(8);
    rd_stat();
    muted_state <= 1'b1;
    rx(3'b000);
    rd_rxd();
    pulse(8);
    rd_stat();
    muted_state <= 1'b0;
    pulse(8);
    rd_stat();
    wr(`USF_OFF_CLR, 32'h50);
    rd_stat();
    clk_en <= 1'b0;
    pulse(0);
    clk_en <= 1'b1;
    rd_stat();
    for (int i = 0; i < 8; i++)
    begin
      pulse(i);
      rd_stat();
      wr(`USF_OFF_CLR, 32'h0);
      rd_stat();
      wr(`USF_OFF_CLR, 32'h1 << sb[i]);
      rd_stat();
    end
    wr(`USF_OFF_CLR, 32'h80);
    rd_stat();
    for (int w = 0; w < 3; w++)
    begin
      int nb;
      nb = (w == 2) ? 7 : 8 + w;
      wr(`USF_OFF_CTRL1, (w == 2) ? 32'h10000400 : (32'h400 | (w << 12)));
      pulse(7);
      rd_stat();
      lfsr_q = lfsr_next(lfsr_q);
      wr(`USF_OFF_TXD, lfsr_q);
      chk("tx valid", {31'h0, tx_char_valid}, 32'h1);
      rd_stat();
      usf_line_partner_inst.load(w * 6, got);
      chk("tx char", got & ((32'h1 << nb) - 1), lfsr_q[8:0] & ((32'h1 << (nb - 1)) - 1));
      m_stat[7] = 1'b1;
      rd_stat();
      chk("tx idle", {31'h0, tx_char_valid}, 32'h0);
    end
    wrap_up();
  end
endmodule
